// ---- hdl/asc_pkg.sv ----
// Constants and types of the scan and trigger control block
// Operation
// - The 16-bit result reads as bits 15..8 at offset 1, 7..0 at offset 0.
// - With software trigger on, any write to offset 0 starts a conversion.
// - A write to offset 2 stores a range code at the scan-first entry.
// - Range byte: bit 5 pairing, bit 4 polarity, bits 2..0 gain code.
// - Bipolar gains 0..4 and unipolar gains 0..3 are assigned, others not.
// - Offsets 4 and 5 hold write-only 6-bit scan-first and scan-last.
// - Writing either scan boundary restarts the scan at scan-first.
// - Each trigger advances the channel and wraps from last to first.
// - With last below first the scan runs up to 63, then 0, up to last.
// - Only even channels go differential and both of a pair read alike.
// - A differential pair takes one entry of the scan sequence.
// - Offset 6 holds trigger, interrupt bits; offset 7 bit 7 calibrates.
// - Interrupt source picks every conversion or FIFO half full.
// - A rising edge of the timer output starts a timed conversion.
package asc_pkg;
  localparam int          AW           = 8;
  localparam int          DW           = 32;
  localparam int          NCH          = 64;
  localparam logic [5:0]  IDX_DATA_LO  = 6'h00;
  localparam logic [5:0]  IDX_DATA_HI  = 6'h01;
  localparam logic [5:0]  IDX_RANGE    = 6'h02;
  localparam logic [5:0]  IDX_FIRST    = 6'h04;
  localparam logic [5:0]  IDX_LAST     = 6'h05;
  localparam logic [5:0]  IDX_CTRL_LO  = 6'h06;
  localparam logic [5:0]  IDX_CTRL_HI  = 6'h07;
  localparam logic [5:0]  IDX_IRQ_STS  = 6'h0c;
  localparam logic [5:0]  IDX_IRQ_MSK  = 6'h0d;
  localparam logic [5:0]  IDX_SEQ      = 6'h0e;
  localparam logic [5:0]  RANGE_KEEP   = 6'h37;
  localparam logic [2:0]  GAIN_BIP_MAX = 3'h4;
  localparam logic [2:0]  GAIN_UNI_MAX = 3'h3;
  localparam logic [5:0]  PAIR_STEP    = 6'h02;
  localparam logic [5:0]  CH_STEP      = 6'h01;
  localparam int          CTRL_SW      = 0;
  localparam int          CTRL_PACER   = 1;
  localparam int          CTRL_IEN     = 4;
  localparam int          CTRL_ISRC    = 5;
  localparam int          CTRL_CAL     = 7;
  localparam int          STS_EVT      = 0;
  localparam int          STS_DONE     = 1;

  typedef struct packed {
    logic       diff;
    logic       uni;
    logic       rsv;
    logic [2:0] gain;
  } asc_range_t;

  typedef struct packed {
    logic cal;
    logic isrc;
    logic ien;
    logic pacer;
    logic sw;
  } asc_ctrl_t;

  typedef struct packed {
    logic       start;
    logic [5:0] chan;
    asc_range_t range;
    logic       range_ok;
  } asc_conv_t;

  typedef struct packed {
    asc_range_t [NCH-1:0] rng;
    logic [5:0]           first;
    logic [5:0]           last;
    logic [5:0]           cur;
    asc_ctrl_t            ctrl;
    logic [15:0]          result;
    logic                 tmr_q;
    logic                 half_q;
    logic [1:0]           sts;
    logic [1:0]           msk;
    asc_conv_t            conv;
  } asc_state_t;
endpackage

// ---- hdl/asc_scan_ctrl.sv ----
// Scan sequencer, trigger select and APB register file of the converter
`timescale 1ns/1ps
`default_nettype none
module asc_scan_ctrl (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              timer_out,
  input  wire logic              fifo_half,
  input  wire logic              conv_done,
  input  wire logic [15:0]       conv_data,
  output asc_pkg::asc_conv_t     conv,
  output logic                   cal_mode,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] asc_idx(input logic [7:0] a);
    return a[7:2];
  endfunction

  function automatic logic asc_known(input logic [5:0] i);
    case (i)
      asc_pkg::IDX_DATA_LO, asc_pkg::IDX_DATA_HI, asc_pkg::IDX_RANGE,
      asc_pkg::IDX_FIRST, asc_pkg::IDX_LAST, asc_pkg::IDX_CTRL_LO,
      asc_pkg::IDX_CTRL_HI, asc_pkg::IDX_IRQ_STS, asc_pkg::IDX_IRQ_MSK,
      asc_pkg::IDX_SEQ: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic asc_gain_ok(input asc_pkg::asc_range_t r);
    if (r.uni) begin
      return r.gain <= asc_pkg::GAIN_UNI_MAX;
    end
    return r.gain <= asc_pkg::GAIN_BIP_MAX;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  asc_pkg::asc_state_t st;
  asc_pkg::asc_state_t next_st;
  logic [5:0]          idx;
  logic                wr;
  logic                rd;
  logic                trig_sw;
  logic                trig_tm;
  logic                trig;
  logic [5:0]          pair;
  logic                diff;
  logic [5:0]          eff_ch;
  logic                at_end;
  logic [5:0]          adv;
  logic                evt_half;
  logic                evt;
  logic [5:0]          wcode;

  assign idx     = asc_idx(paddr);
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign trig_sw = wr && idx == asc_pkg::IDX_DATA_LO && st.ctrl.sw;
  assign trig_tm = st.ctrl.pacer && timer_out && !st.tmr_q;
  assign trig    = trig_sw | trig_tm;
  assign pair    = {st.cur[5:1], 1'b0};
  assign diff    = st.rng[pair].diff;
  assign eff_ch  = diff ? pair : st.cur;
  assign at_end  = (st.cur == st.last) ||
                   (diff && {st.last[5:1], 1'b0} == pair);
  // Six-bit sums roll from 63 to 0 by themselves
  assign adv     = at_end ? st.first :
                   diff ? 6'(pair + asc_pkg::PAIR_STEP) :
                   6'(st.cur + asc_pkg::CH_STEP);
  assign evt_half = fifo_half & ~st.half_q;
  assign evt     = st.ctrl.isrc ? evt_half : conv_done;
  // Odd entries never keep the pairing bit
  assign wcode   = pwdata[5:0] & asc_pkg::RANGE_KEEP &
                   {~st.first[0], 5'h1f};

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st            = st;
    next_st.tmr_q      = timer_out;
    next_st.half_q     = fifo_half;
    next_st.conv.start = 1'b0;
    if (trig) begin
      next_st.conv.start    = 1'b1;
      next_st.conv.chan     = eff_ch;
      next_st.conv.range    = st.rng[eff_ch];
      next_st.conv.range_ok = asc_gain_ok(st.rng[eff_ch]);
      next_st.cur           = adv;
    end
    if (conv_done) begin
      next_st.result = conv_data;
    end
    if (wr) begin
      case (idx)
        asc_pkg::IDX_RANGE: begin
          next_st.rng[st.first] = wcode;
        end
        asc_pkg::IDX_FIRST: begin
          next_st.first = pwdata[5:0];
          next_st.cur   = pwdata[5:0];
        end
        asc_pkg::IDX_LAST: begin
          next_st.last = pwdata[5:0];
          next_st.cur  = st.first;
        end
        asc_pkg::IDX_CTRL_LO: begin
          next_st.ctrl.sw    = pwdata[asc_pkg::CTRL_SW];
          next_st.ctrl.pacer = pwdata[asc_pkg::CTRL_PACER];
          next_st.ctrl.ien   = pwdata[asc_pkg::CTRL_IEN];
          next_st.ctrl.isrc  = pwdata[asc_pkg::CTRL_ISRC];
        end
        asc_pkg::IDX_CTRL_HI: begin
          next_st.ctrl.cal = pwdata[asc_pkg::CTRL_CAL];
        end
        asc_pkg::IDX_IRQ_STS: begin
          next_st.sts = st.sts & ~pwdata[1:0];
        end
        asc_pkg::IDX_IRQ_MSK: begin
          next_st.msk = pwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    next_st.sts[asc_pkg::STS_EVT]  = next_st.sts[asc_pkg::STS_EVT] | evt;
    next_st.sts[asc_pkg::STS_DONE] = next_st.sts[asc_pkg::STS_DONE] |
                                     conv_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    prdata = '0;
    if (rd) begin
      case (idx)
        asc_pkg::IDX_DATA_LO: prdata[7:0] = st.result[7:0];
        asc_pkg::IDX_DATA_HI: prdata[7:0] = st.result[15:8];
        asc_pkg::IDX_IRQ_STS: prdata[1:0] = st.sts;
        asc_pkg::IDX_IRQ_MSK: prdata[1:0] = st.msk;
        asc_pkg::IDX_SEQ:     prdata[5:0] = st.cur;
        default:              prdata      = '0;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & (~asc_known(idx) |
                   (pwrite & (idx == asc_pkg::IDX_DATA_HI |
                              idx == asc_pkg::IDX_SEQ)));
  assign conv     = st.conv;
  assign cal_mode = st.ctrl.cal;
  assign irq      = st.ctrl.ien & |(st.sts & st.msk);

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A scan boundary write in the same cycle as a trigger decides the channel
  logic bnd_wr;
  assign bnd_wr = wr && (idx == asc_pkg::IDX_FIRST ||
                         idx == asc_pkg::IDX_LAST);

  sequence s_wr(logic [5:0] i);
    wr && idx == i;
  endsequence

  sequence s_start_on(logic [5:0] c);
    conv.start && conv.chan == c;
  endsequence

  property p_sw_trig;
    s_wr(asc_pkg::IDX_DATA_LO) ##0 st.ctrl.sw |=> conv.start;
  endproperty
  a_sw_trig: assert property (p_sw_trig)
    else $error("software trigger did not start a conversion");

  property p_no_trig;
    !trig |=> !conv.start;
  endproperty
  a_no_trig: assert property (p_no_trig)
    else $error("conversion started without a trigger");

  property p_timed;
    st.ctrl.pacer && $rose(timer_out) && st.tmr_q == 1'b0
      |=> conv.start;
  endproperty
  a_timed: assert property (p_timed)
    else $error("timer edge did not start a conversion");

  property p_first_restart;
    logic [5:0] v;
    (s_wr(asc_pkg::IDX_FIRST), v = pwdata[5:0]) ##1 trig
      |=> s_start_on(v) or
          s_start_on({v[5:1], 1'b0});
  endproperty
  a_first_restart: assert property (p_first_restart)
    else $error("scan did not restart at the first channel");

  property p_last_restart;
    s_wr(asc_pkg::IDX_LAST) ##0 !trig |=> st.cur == $past(st.first);
  endproperty
  a_last_restart: assert property (p_last_restart)
    else $error("last write did not reset the scan");

  property p_wrap_end;
    trig && at_end && !bnd_wr |=> st.cur == $past(st.first);
  endproperty
  a_wrap_end: assert property (p_wrap_end)
    else $error("scan did not return to first after last");

  property p_wrap_top;
    trig && !at_end && !bnd_wr && st.cur == 6'h3f |=> st.cur == 6'h00;
  endproperty
  a_wrap_top: assert property (p_wrap_top)
    else $error("scan did not roll from 63 to 0");

  property p_diff_even;
    conv.start && conv.range.diff |-> conv.chan[0] == 1'b0;
  endproperty
  a_diff_even: assert property (p_diff_even)
    else $error("differential conversion on an odd channel");

  property p_pair_skip;
    trig && diff && !at_end && !bnd_wr |=> st.cur == $past(pair) + 6'h02;
  endproperty
  a_pair_skip: assert property (p_pair_skip)
    else $error("differential pair took two scan entries");

  property p_result;
    conv_done ##1 rd && idx == asc_pkg::IDX_DATA_HI
      |-> prdata[7:0] == $past(conv_data[15:8]) && prdata[31:8] == '0;
  endproperty
  a_result: assert property (p_result)
    else $error("high result byte read back wrong");

  property p_range_store;
    logic [5:0] f;
    (s_wr(asc_pkg::IDX_RANGE) ##0 !st.first[0], f = st.first)
      |=> st.rng[f] == ($past(pwdata[5:0]) & asc_pkg::RANGE_KEEP);
  endproperty
  a_range_store: assert property (p_range_store)
    else $error("range code not stored at the first channel");

  property p_ctrl;
    s_wr(asc_pkg::IDX_CTRL_LO) |=> st.ctrl.sw == $past(pwdata[0]) &&
      st.ctrl.isrc == $past(pwdata[5]) && st.ctrl.ien == $past(pwdata[4]);
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control bits not taken from the write");

  property p_gain_ok;
    conv.start && !conv.range.uni && conv.range.gain == 3'h5
      |-> !conv.range_ok;
  endproperty
  a_gain_ok: assert property (p_gain_ok)
    else $error("unassigned bipolar gain marked valid");

  property p_irq_src;
    st.ctrl.isrc == 1'b0 && conv_done ##1
      !(wr && idx == asc_pkg::IDX_IRQ_STS) |-> st.sts[0] [*2];
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("conversion event did not hold its status bit");

endmodule // asc_scan_ctrl
`default_nettype wire

// ---- dv/test_adc_scan_trigger_control.sv ----
// Self-checking testbench of the scan and trigger control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_scan_trigger_control;
  logic               pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               pready, pslverr, timer_out, fifo_half;
  logic               conv_done, cal_mode, irq;
  logic [15:0]        conv_data;
  asc_pkg::asc_conv_t conv;
  int                 n_errors = 0;
  int                 check_count = 0;

  asc_scan_ctrl asc_scan_ctrl_inst (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .timer_out (timer_out),
    .fifo_half (fifo_half),
    .conv_done (conv_done),
    .conv_data (conv_data),
    .conv      (conv),
    .cal_mode  (cal_mode),
    .irq       (irq)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out;
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; read data and error are taken at the pready edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Software trigger, then the launched conversion request is judged
  task automatic trig(logic [5:0] ch, logic [5:0] rng, logic ok);
    apb(1'b1, 8'h00, 32'h0000_00ff);
    #1;
    check("conv", 32'(conv), 32'({1'b1, ch, rng, ok}));
  endtask

  task automatic setrange(logic [7:0] ch, logic [7:0] code);
    apb(1'b1, 8'h10, 32'(ch));
    apb(1'b1, 8'h14, 32'(ch));
    apb(1'b1, 8'h08, 32'(code));
  endtask

  task automatic done(logic [15:0] d);
    @(posedge pclk);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge pclk);
    conv_done <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_result;
    done(16'ha5c3);
    apb(1'b0, 8'h00, 32'h0);
    check("result_low", rd, 32'h0000_00c3);
    apb(1'b0, 8'h04, 32'h0);
    check("result_high", rd, 32'h0000_00a5);
    // A result landing during the read setup shows in the same read
    fork
      apb(1'b0, 8'h04, 32'h0);
      done(16'h5a3c);
    join
    check("result_fresh", rd, 32'h0000_005a);
  endtask

  task automatic t_ranges;
    setrange(8'h04, 8'h31);
    setrange(8'h06, 8'h14);
    setrange(8'h07, 8'hcc);
    apb(1'b1, 8'h10, 32'h04);
    apb(1'b1, 8'h14, 32'h07);
    apb(1'b1, 8'h18, 32'h01);
    trig(6'h04, 6'h31, 1'b1);
    trig(6'h06, 6'h14, 1'b0);
    trig(6'h07, 6'h04, 1'b1);
    trig(6'h04, 6'h31, 1'b1);
    apb(1'b1, 8'h10, 32'h05);
    apb(1'b1, 8'h14, 32'h05);
    trig(6'h04, 6'h31, 1'b1);
  endtask

  task automatic t_scan;
    logic [5:0] seq [5] = '{6'h3e, 6'h3f, 6'h00, 6'h01, 6'h3e};
    apb(1'b1, 8'h10, 32'h3e);
    apb(1'b1, 8'h14, 32'h01);
    foreach (seq[i]) trig(seq[i], 6'h00, 1'b1);
    trig(6'h3f, 6'h00, 1'b1);
    apb(1'b1, 8'h14, 32'hc1);
    trig(6'h3e, 6'h00, 1'b1);
    apb(1'b1, 8'h18, 32'h00);
    setrange(8'h3e, 8'h05);
    apb(1'b1, 8'h18, 32'h01);
    trig(6'h3e, 6'h05, 1'b0);
  endtask

  task automatic t_timed;
    apb(1'b1, 8'h18, 32'h02);
    apb(1'b1, 8'h00, 32'h0);
    #1;
    check("sw_ignored", 32'(conv.start), 32'h0);
    // Timer edge right after a scan-first write: pair 4/5 is differential
    apb(1'b1, 8'h10, 32'h05);
    timer_out <= 1'b1;
    @(posedge pclk);
    #1;
    check("timed", 32'(conv), 32'({1'b1, 6'h04, 6'h31, 1'b1}));
    @(posedge pclk);
    #1;
    check("timed_once", 32'(conv.start), 32'h0);
    @(posedge pclk);
    timer_out <= 1'b0;
  endtask

  task automatic t_irq;
    apb(1'b1, 8'h30, 32'h3);
    apb(1'b1, 8'h34, 32'h3);
    apb(1'b1, 8'h18, 32'h10);
    #1;
    check("irq_idle", 32'(irq), 32'h0);
    done(16'h0001);
    check("irq_conv", 32'(irq), 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    check("status", rd, 32'h3);
    apb(1'b1, 8'h30, 32'h3);
    #1;
    check("irq_clear", 32'(irq), 32'h0);
    apb(1'b1, 8'h18, 32'h30);
    apb(1'b1, 8'h34, 32'h1);
    done(16'h0002);
    check("irq_masked", 32'(irq), 32'h0);
    @(posedge pclk);
    fifo_half <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    check("irq_half", 32'(irq), 32'h1);
    apb(1'b1, 8'h34, 32'h0);
    #1;
    check("irq_mask_off", 32'(irq), 32'h0);
    apb(1'b1, 8'h1c, 32'h80);
    #1;
    check("cal_mode", 32'(cal_mode), 32'h1);
  endtask

  task automatic t_refuse;
    apb(1'b1, 8'h04, 32'h0);
    check("err_ro", 32'(err), 32'h1);
    apb(1'b0, 8'h3c, 32'h0);
    check("err_unmapped", 32'(err), 32'h1);
    apb(1'b0, 8'h38, 32'h0);
    check("err_ok", 32'(err), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timer_out = 1'b0;
    fifo_half = 1'b0;
    conv_done = 1'b0;
    conv_data = 16'h0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check("irq_reset", 32'(irq), 32'h0);
    t_result();
    t_ranges();
    t_scan();
    t_timed();
    t_irq();
    t_refuse();
    close_out();
  end
endmodule // test_adc_scan_trigger_control
`default_nettype wire
